// file: core/acs_sequencer.sv
// Purpose: Start protocol, busy flag, timing, routing and result for a 12-bit converter.
// Assumes: APB slave with zero wait states; analog macro supplies result bits.
// Notes: Converter clock exists only as strobes from acs_clkdiv.
// Functional notes
// - Start only after start bit high then low.
// - Start high holds converter reset, busy cleared.
// - Busy set on start, cleared on completion.
// - Completion sets request flag; enabled raises interrupt.
// - Converter clock is system clock over two-power.
// - Enable powers converter; software waits settling.
// - Reference field selects; amplifier needs enable first.
// - Analog pin drops pull-up, direction, other functions.
// - Unlisted internal codes route chosen external channel.
// - Internal codes map to internal sources.
// - Internal input wins over external channel.
// - Internal reference wins over external pin.
// - Bandgap wins over amplifier input pin.
// - Four sample cycles then twelve conversion cycles.
// - Result stored, latched half cycle later.
// - Format bit selects left or right justification.
// - Disabled converter leaves result registers unchanged.
// - Reference decode: supply, pin, amplifier.
module acs_sequencer #(
   parameter int DIV_W = 3,
   parameter int PINS = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog converter macro.
   input wire logic [acs_pkg::RESULT_BITS-1:0] conv_data,
   output logic conv_power_enable,
   output logic conv_reset,
   output logic conv_sample,
   output logic conv_convert,
   output logic conv_clk_strobe,
   output logic [3:0] input_route,
   output logic [3:0] external_channel_sel,
   output logic [1:0] reference_route,
   output logic amplifier_enable,
   output logic amplifier_input_bg,
   // Port pin control.
   output logic [PINS-1:0] pin_analog,
   output logic [PINS-1:0] pin_pullup_disable,
   output logic [PINS-1:0] pin_dir_override,
   // Interrupt controller side.
   input wire logic conv_irq_enable,
   output logic conv_irq_req,
   output logic conv_irq
);
   logic [7:0] ctrl0_r, ctrl0_nxt, ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt;
   logic [7:0] pin_lo_r, pin_lo_nxt, pin_hi_r, pin_hi_nxt;
   logic [7:0] res_lo_r, res_lo_nxt, res_hi_r, res_hi_nxt;
   logic [acs_pkg::RESULT_BITS-1:0] stage_r, stage_nxt;
   logic latch_pend_r, latch_pend_nxt;
   logic busy_r, busy_nxt, irqf_r, irqf_nxt;
   logic [4:0] cyc_r, cyc_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   acs_pkg::acs_state_t st_r, st_nxt;
   logic wr, rd, start_bit, en, done, rise, fall;

   acs_clkdiv #(.DIV_W(DIV_W)) u_div (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .run(en),
      .div_sel(ctrl1_r[DIV_W-1:0]),
      .rise(rise),
      .fall(fall)
   );

   // Decodes a 4-bit internal select into the routed source; unlisted codes fall to external.
   function automatic logic [3:0] route_input(input logic [3:0] ins);
      case (ins)
         acs_pkg::IN_SUPPLY, acs_pkg::IN_SUPPLY_2, acs_pkg::IN_SUPPLY_4,
         acs_pkg::IN_AMP, acs_pkg::IN_AMP_2, acs_pkg::IN_AMP_4,
         acs_pkg::IN_CUR_AMP, acs_pkg::IN_OV_TAP, acs_pkg::IN_BAT_TAP,
         acs_pkg::IN_GROUND: route_input = ins;
         default: route_input = acs_pkg::IN_EXTERNAL;
      endcase
   endfunction : route_input

   // Places the 12-bit result in a 16-bit pair per the format bit.
   function automatic logic [15:0] justify(input logic fmt,
                                           input logic [acs_pkg::RESULT_BITS-1:0] d);
      if (fmt)
         justify = {4'h0, d};
      else
         justify = {d, 4'h0};
   endfunction : justify

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_r;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign start_bit = ctrl0_r[acs_pkg::C0_START];
   assign en = ctrl0_r[acs_pkg::C0_EN];
   assign conv_power_enable = en;
   assign conv_clk_strobe = rise;
   assign conv_reset = (st_r == acs_pkg::ST_RESET);
   assign conv_sample = (st_r == acs_pkg::ST_RUN) && (cyc_r < 5'(acs_pkg::SAMPLE_CYCLES));
   assign conv_convert = (st_r == acs_pkg::ST_RUN) && !conv_sample;
   assign input_route = route_input(ctrl1_r[7:4]);
   assign external_channel_sel = ctrl0_r[3:0];
   // Any reference code other than the pin is internal, so the internal source wins.
   assign reference_route = ctrl2_r[3] ? acs_pkg::REF_AMP : ctrl2_r[3:2];
   assign amplifier_enable = ctrl2_r[acs_pkg::C2_AMP_EN];
   assign amplifier_input_bg = ctrl2_r[acs_pkg::C2_AMP_IN];
   // Each pin uses two select bits; nonzero pair marks the pin analog.
   always_comb
   begin
      for (int i = 0; i < PINS; i++)
      begin
         if (i < 4)
            pin_analog[i] = |pin_lo_r[2*i +: 2];
         else
            pin_analog[i] = |pin_hi_r[2*(i-4) +: 2];
      end
   end
   assign pin_pullup_disable = pin_analog;
   assign pin_dir_override = pin_analog;
   assign conv_irq_req = irqf_r;
   assign conv_irq = irqf_r && conv_irq_enable;
   assign done = (st_r == acs_pkg::ST_RUN) && rise && (cyc_r == 5'(acs_pkg::TOTAL_CYCLES - 1));

   // Register writes and reads.
   always_comb
   begin
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      pin_lo_nxt = pin_lo_r;
      pin_hi_nxt = pin_hi_r;
      irqf_nxt = irqf_r;
      prdata_nxt = prdata_r;
      if (wr)
      begin
         case (paddr)
            acs_pkg::ADDR_CTRL0: ctrl0_nxt = pwdata[7:0] & 8'hbf;
            acs_pkg::ADDR_CTRL1: ctrl1_nxt = pwdata[7:0] & 8'hf7;
            acs_pkg::ADDR_CTRL2: ctrl2_nxt = pwdata[7:0] & 8'h9f;
            acs_pkg::ADDR_PIN_LO: pin_lo_nxt = pwdata[7:0];
            acs_pkg::ADDR_PIN_HI: pin_hi_nxt = pwdata[7:0];
            acs_pkg::ADDR_IRQ: if (pwdata[0]) irqf_nxt = 1'b0;
            default: ;
         endcase
      end
      if (done)
         irqf_nxt = 1'b1;
      if (rd)
      begin
         case (paddr)
            acs_pkg::ADDR_CTRL0: prdata_nxt = {24'h0, ctrl0_r[7], busy_r, ctrl0_r[5:0]};
            acs_pkg::ADDR_CTRL1: prdata_nxt = {24'h0, ctrl1_r};
            acs_pkg::ADDR_CTRL2: prdata_nxt = {24'h0, ctrl2_r};
            acs_pkg::ADDR_RES_LO: prdata_nxt = {24'h0, res_lo_r};
            acs_pkg::ADDR_RES_HI: prdata_nxt = {24'h0, res_hi_r};
            acs_pkg::ADDR_PIN_LO: prdata_nxt = {24'h0, pin_lo_r};
            acs_pkg::ADDR_PIN_HI: prdata_nxt = {24'h0, pin_hi_r};
            acs_pkg::ADDR_IRQ: prdata_nxt = {31'h0, irqf_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Start protocol and conversion timing.
   always_comb
   begin
      st_nxt = st_r;
      cyc_nxt = cyc_r;
      busy_nxt = busy_r;
      stage_nxt = stage_r;
      latch_pend_nxt = latch_pend_r;
      res_lo_nxt = res_lo_r;
      res_hi_nxt = res_hi_r;
      case (st_r)
         acs_pkg::ST_IDLE:
            if (start_bit)
               st_nxt = acs_pkg::ST_RESET;
         acs_pkg::ST_RESET:
         begin
            busy_nxt = 1'b0;
            if (!start_bit)
               st_nxt = acs_pkg::ST_ARMED;
         end
         acs_pkg::ST_ARMED:
            if (start_bit)
               st_nxt = acs_pkg::ST_RESET;
            else if (en && rise)
            begin
               st_nxt = acs_pkg::ST_RUN;
               busy_nxt = 1'b1;
               cyc_nxt = 5'h00;
            end
         acs_pkg::ST_RUN:
            if (start_bit)
               st_nxt = acs_pkg::ST_RESET;
            else if (done)
            begin
               st_nxt = acs_pkg::ST_IDLE;
               busy_nxt = 1'b0;
               stage_nxt = conv_data;
               latch_pend_nxt = 1'b1;
            end
            else if (rise)
               cyc_nxt = cyc_r + 5'h01;
         default: st_nxt = acs_pkg::ST_IDLE;
      endcase
      // Clearing on the start edge itself keeps a read in the next cycle from seeing busy.
      if (start_bit)
         busy_nxt = 1'b0;
      // Result latches on the next falling converter edge; a start first
      // disturbs it, as the hardware it mirrors does.
      if (latch_pend_r && start_bit)
      begin
         stage_nxt = conv_data;
         latch_pend_nxt = 1'b0;
      end
      else if (latch_pend_r && fall && en)
      begin
         {res_hi_nxt, res_lo_nxt} = justify(ctrl0_r[acs_pkg::C0_FMT], stage_r);
         latch_pend_nxt = 1'b0;
      end
      if (!en)
      begin
         latch_pend_nxt = latch_pend_r;
         res_lo_nxt = res_lo_r;
         res_hi_nxt = res_hi_r;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         ctrl0_r <= acs_pkg::RST_BYTE;
         ctrl1_r <= acs_pkg::RST_BYTE;
         ctrl2_r <= acs_pkg::RST_BYTE;
         pin_lo_r <= acs_pkg::RST_BYTE;
         pin_hi_r <= acs_pkg::RST_BYTE;
         res_lo_r <= acs_pkg::RST_BYTE;
         res_hi_r <= acs_pkg::RST_BYTE;
         stage_r <= '0;
         latch_pend_r <= 1'b0;
         busy_r <= 1'b0;
         irqf_r <= 1'b0;
         cyc_r <= 5'h00;
         prdata_r <= 32'h0000_0000;
         st_r <= acs_pkg::ST_IDLE;
      end
      else
      begin
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= ctrl2_nxt;
         pin_lo_r <= pin_lo_nxt;
         pin_hi_r <= pin_hi_nxt;
         res_lo_r <= res_lo_nxt;
         res_hi_r <= res_hi_nxt;
         stage_r <= stage_nxt;
         latch_pend_r <= latch_pend_nxt;
         busy_r <= busy_nxt;
         irqf_r <= irqf_nxt;
         cyc_r <= cyc_nxt;
         prdata_r <= prdata_nxt;
         st_r <= st_nxt;
      end
   end
endmodule : acs_sequencer

// file: pkg/acs_pkg.sv
// Purpose: Shared constants for the converter sequencer.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes: Register bytes sit in the low eight bits of each word.
package acs_pkg;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_CTRL2 = 8'h08;
   localparam logic [7:0] ADDR_RES_LO = 8'h0c;
   localparam logic [7:0] ADDR_RES_HI = 8'h10;
   localparam logic [7:0] ADDR_PIN_LO = 8'h14;
   localparam logic [7:0] ADDR_PIN_HI = 8'h18;
   localparam logic [7:0] ADDR_IRQ = 8'h1c;
   // Control register 0 fields.
   localparam int C0_START = 7;
   localparam int C0_BUSY = 6;
   localparam int C0_EN = 5;
   localparam int C0_FMT = 4;
   // Control register 1 and 2 fields.
   localparam int C1_INS_LSB = 4;
   localparam int C2_AMP_EN = 7;
   localparam int C2_AMP_IN = 4;
   localparam int C2_REF_LSB = 2;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Conversion timing in converter clock cycles; result width in bits.
   localparam int SAMPLE_CYCLES = 4;
   localparam int CONVERT_CYCLES = 12;
   localparam int TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;
   localparam int RESULT_BITS = 12;
   // Reference decode.
   localparam logic [1:0] REF_SUPPLY = 2'h0;
   localparam logic [1:0] REF_PIN = 2'h1;
   localparam logic [1:0] REF_AMP = 2'h2;
   // Analog input routing codes presented to the analog macro.
   localparam logic [3:0] IN_EXTERNAL = 4'h0;
   localparam logic [3:0] IN_SUPPLY = 4'h1;
   localparam logic [3:0] IN_SUPPLY_2 = 4'h2;
   localparam logic [3:0] IN_SUPPLY_4 = 4'h3;
   localparam logic [3:0] IN_AMP = 4'h5;
   localparam logic [3:0] IN_AMP_2 = 4'h6;
   localparam logic [3:0] IN_AMP_4 = 4'h7;
   localparam logic [3:0] IN_CUR_AMP = 4'h8;
   localparam logic [3:0] IN_OV_TAP = 4'h9;
   localparam logic [3:0] IN_BAT_TAP = 4'ha;
   localparam logic [3:0] IN_GROUND = 4'hb;
   typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_ARMED, ST_RUN} acs_state_t;
endpackage : acs_pkg

// file: core/acs_clkdiv.sv
// Purpose: Divides the system clock into converter clock edge strobes.
// Assumes: Divider code 0 divides by one, each step doubles.
// Notes: Outputs one-cycle rise and fall strobes; no derived clock net.
module acs_clkdiv #(
   parameter int DIV_W = 3
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Control.
   input wire logic run,
   input wire logic [DIV_W-1:0] div_sel,
   // Strobes.
   output logic rise,
   output logic fall
);
   localparam int CW = (1 << DIV_W);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] half;
   logic phase_r;
   logic phase_nxt;

   // With divide by one both edges share each system cycle, so phase holds its value.
   always_comb
   begin
      half = CW'(1) << div_sel;
      half = half >> 1;
      cnt_nxt = cnt_r;
      phase_nxt = phase_r;
      rise = 1'b0;
      fall = 1'b0;
      if (!run)
      begin
         cnt_nxt = '0;
         phase_nxt = 1'b0;
      end
      else if (div_sel == '0)
      begin
         rise = 1'b1;
         fall = 1'b1;
      end
      // Greater-or-equal recovers at once when the divider code is lowered mid-count.
      else if (cnt_r >= half - CW'(1))
      begin
         cnt_nxt = '0;
         phase_nxt = !phase_r;
         rise = !phase_r;
         fall = phase_r;
      end
      else
      begin
         cnt_nxt = cnt_r + CW'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         cnt_r <= '0;
         phase_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
      end
   end
endmodule : acs_clkdiv

// file: tb/acs_sequencer_asserts.sv
// Purpose: Concurrent checks on the converter sequencer ports.
// Assumes: Bound to acs_sequencer; a single clock domain.
// Notes: Only the ports that the checks need are declared.
module acs_sequencer_asserts #(
   parameter int PINS = 8
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Converter control.
   input wire logic conv_power_enable,
   input wire logic conv_reset,
   input wire logic conv_sample,
   input wire logic conv_convert,
   input wire logic [3:0] input_route,
   // Pin control.
   input wire logic [PINS-1:0] pin_analog,
   input wire logic [PINS-1:0] pin_pullup_disable,
   input wire logic [PINS-1:0] pin_dir_override,
   // Interrupt side.
   input wire logic conv_irq_enable,
   input wire logic conv_irq_req,
   input wire logic conv_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   property p_reset_quiet;
      conv_reset |-> !conv_sample && !conv_convert;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("converter active while held in reset");
   property p_start_released;
      $rose(conv_sample) |-> !conv_reset;
   endproperty
   a_start_released: assert property (p_start_released)
      else $error("sampling began with start still high");
   property p_power_gate;
      $rose(conv_sample) |-> conv_power_enable;
   endproperty
   a_power_gate: assert property (p_power_gate)
      else $error("sampling began while powered down");
   property p_sample_then_convert;
      $fell(conv_sample) && !conv_reset |-> conv_convert;
   endproperty
   a_sample_then_convert: assert property (p_sample_then_convert)
      else $error("conversion phase did not follow sampling");
   property p_done_flag;
      $fell(conv_convert) && !conv_reset |-> ##[0:2] conv_irq_req;
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("request flag missing after conversion");
   property p_irq_line;
      conv_irq == (conv_irq_req && conv_irq_enable);
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt line disagrees with flag and enable");
   property p_route_legal;
      input_route != 4'h4 && input_route < 4'hc;
   endproperty
   a_route_legal: assert property (p_route_legal)
      else $error("illegal input route code");
   property p_pin_analog;
      pin_pullup_disable == pin_analog && pin_dir_override == pin_analog;
   endproperty
   a_pin_analog: assert property (p_pin_analog)
      else $error("analog pin kept pull-up or direction control");
endmodule : acs_sequencer_asserts

// file: tb/testbench.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: APB slave answers through pready; results follow conv_data.
// Notes: Every divider code is run, so the run lasts some thousands of cycles.
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [11:0] conv_data = 12'h000;
   logic conv_irq_enable = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, conv_power_enable, conv_reset, conv_sample, conv_convert;
   logic conv_clk_strobe, amplifier_enable, amplifier_input_bg, conv_irq_req, conv_irq;
   logic [3:0] input_route, external_channel_sel;
   logic [1:0] reference_route;
   logic [7:0] pin_analog, pin_pullup_disable, pin_dir_override, v, b;
   logic [11:0] r;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int ns = 0;
   int nc = 0;
   int nk = 0;
   // Inputs are {select code, reference field}; outputs are {route, reference}.
   logic [11:0] rows [16] = '{12'h000, 12'h145, 12'h28a, 12'h3ce, 12'h400, 12'h555,
      12'h69a, 12'h7de, 12'h820, 12'h965, 12'haaa, 12'hbee, 12'hc00, 12'hd41, 12'he82,
      12'hfc2};
   acs_sequencer i_acs_sequencer (.*);
   always #10 clk_sys = ~clk_sys;
   // The ceiling allows the slowest divider codes with ample margin.
   always @(posedge clk_sys)
   begin
      cyc++;
      ns += int'(conv_sample === 1'b1);
      nc += int'(conv_convert === 1'b1);
      nk += int'(conv_clk_strobe === 1'b1 && (conv_sample === 1'b1 || conv_convert === 1'b1));
      if (cyc == 40000)
      begin
         fail_count++;
         test_done();
      end
   end
   task test_done;
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   function automatic logic [3:0] an(input logic [7:0] x);
      for (int j = 0; j < 4; j++)
         an[j] = |x[2*j +: 2];
   endfunction : an
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      v = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task conv(input logic [2:0] d);
      int s0;
      int c0;
      int k0;
      logic [11:0] dat;
      dat = 12'h5a3 ^ {d, d, d, d};
      conv_data <= dat;
      conv_irq_enable <= d[1];
      apb(1'b1, acs_pkg::ADDR_CTRL1, {5'h00, d});
      apb(1'b1, acs_pkg::ADDR_CTRL0, {3'h5, d[0], 4'h2});
      apb(1'b0, acs_pkg::ADDR_CTRL0, 8'h00);
      `CHK("held reset", 1'b1, conv_reset)
      `CHK("busy in reset", 1'b0, v[6])
      s0 = ns;
      c0 = nc;
      k0 = nk;
      apb(1'b1, acs_pkg::ADDR_CTRL0, {3'h1, d[0], 4'h2});
      do @(posedge clk_sys); while (conv_sample !== 1'b1);
      apb(1'b0, acs_pkg::ADDR_CTRL0, 8'h00);
      `CHK("busy set", 1'b1, v[6])
      do @(posedge clk_sys); while (conv_irq_req !== 1'b1);
      `CHK("sample cycles", 4 << d, ns - s0)
      `CHK("convert cycles", 12 << d, nc - c0)
      `CHK("strobes", acs_pkg::TOTAL_CYCLES, nk - k0)
      `CHK("irq line", d[1], conv_irq)
      // Reading too early would catch the result before its late latch.
      repeat ((1 << d) + 2) @(posedge clk_sys);
      apb(1'b0, acs_pkg::ADDR_RES_HI, 8'h00);
      `CHK("result high", d[0] ? {4'h0, dat[11:8]} : dat[11:4], v)
      apb(1'b0, acs_pkg::ADDR_RES_LO, 8'h00);
      `CHK("result low", d[0] ? dat[7:0] : {dat[3:0], 4'h0}, v)
      apb(1'b0, acs_pkg::ADDR_CTRL0, 8'h00);
      `CHK("busy cleared", 1'b0, v[6])
      apb(1'b0, acs_pkg::ADDR_IRQ, 8'h00);
      `CHK("irq flag", 1'b1, v[0])
      apb(1'b1, acs_pkg::ADDR_IRQ, 8'h01);
      apb(1'b0, acs_pkg::ADDR_IRQ, 8'h00);
      `CHK("irq cleared", 1'b0, v[0])
   endtask : conv
   initial
   begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 16; i++)
      begin
         r = rows[i];
         b = {r[11:8], ~r[11:8]};
         apb(1'b1, acs_pkg::ADDR_CTRL0, {4'h2, ~r[11:8]});
         apb(1'b1, acs_pkg::ADDR_CTRL1, {r[11:8], 4'h0});
         // The amplifier is kept on whenever it serves as the reference.
         apb(1'b1, acs_pkg::ADDR_CTRL2, {r[8] | r[7], 2'h0, r[9], r[7:6], 2'h0});
         apb(1'b1, acs_pkg::ADDR_PIN_LO, b);
         apb(1'b1, acs_pkg::ADDR_PIN_HI, b);
         `CHK("input route", r[5:2], input_route)
         `CHK("reference route", r[1:0], reference_route)
         `CHK("channel", ~r[11:8], external_channel_sel)
         `CHK("amp enable", r[8] | r[7], amplifier_enable)
         `CHK("amp input", r[9], amplifier_input_bg)
         `CHK("analog pins", {an(b), an(b)}, pin_analog)
         `CHK("power", 1'b1, conv_power_enable)
      end
      // Only codes 5 to 7 keep the converter period in the recommended range here.
      for (int k = 0; k < 8; k++)
         conv(3'(k));
      apb(1'b1, acs_pkg::ADDR_CTRL1, 8'h00);
      apb(1'b0, acs_pkg::ADDR_RES_HI, 8'h00);
      r[7:0] = v;
      apb(1'b1, acs_pkg::ADDR_CTRL0, 8'ha0);
      apb(1'b1, acs_pkg::ADDR_CTRL0, 8'h20);
      do @(posedge clk_sys); while (conv_sample !== 1'b1);
      apb(1'b1, acs_pkg::ADDR_CTRL0, 8'ha0);
      apb(1'b0, acs_pkg::ADDR_CTRL0, 8'h00);
      `CHK("busy after abort", 1'b0, v[6])
      `CHK("abort reset", 1'b1, conv_reset)
      conv_data <= 12'hfff;
      apb(1'b1, acs_pkg::ADDR_CTRL0, 8'h80);
      apb(1'b1, acs_pkg::ADDR_CTRL0, 8'h00);
      repeat (40) @(posedge clk_sys);
      `CHK("idle when off", 1'b0, conv_sample)
      apb(1'b0, acs_pkg::ADDR_RES_HI, 8'h00);
      `CHK("kept result", r[7:0], v)
      apb(1'b1, acs_pkg::ADDR_CTRL0, 8'ha0);
      repeat (20) @(posedge clk_sys);
      `CHK("no start on rise", 1'b0, conv_sample)
      apb(1'b0, 8'h20, 8'h00);
      `CHK("unmapped read", 8'h00, v)
      `CHK("slave error", 1'b0, pslverr)
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, acs_pkg::ADDR_CTRL0, 8'h00);
      `CHK("control after reset", acs_pkg::RST_BYTE, v)
      test_done();
   end
endmodule : testbench
bind acs_sequencer acs_sequencer_asserts #(.PINS(PINS)) i_acs_sequencer_asserts (.*);
